// *** bbcc_connect_ctl.sv ***
// Two-wire slave and control registers of an addressable bus buffer.
// Assumes analog switches, accelerators and GPIO drivers outside follow
// the registered control outputs; pins are asynchronous to clk_i.
// Summary of operation
// R1 - Card attach low resets all control registers at once, with no clock.
// R2 - Reset state: sides disconnected, accelerators off, GPIOs open-drain released.
// R3 - After card attach returns high registers stay default until written and are accessible.
// R4 - Backplane and card accelerators are enabled independently in any combination.
// R5 - Pulses on the backplane data and clock of up to 50 ns never reach the slave.
// R6 - Undervoltage on either supply breaks the connection between the sides.
// R7 - The card bus stays isolated until a connect command has been written.
// R8 - Written bytes commit only at a stop; a start before the stop drops them.
// R9 - While disconnected only backplane lines are heard by the slave.
// R10 - First register reads three control bits, two GPIO states and 000.
// R11 - Word writes store bytes one and two and acknowledge but drop the third.
// R12 - Filtering uses a synchroniser and a counter demanding a stable level.
`timescale 1ns/1ps
module bbcc_connect_ctl
    import bbcc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic card_attach_i,
    input wire logic bp_sda_i,
    input wire logic bp_scl_i,
    input wire logic card_sda_i,
    input wire logic card_scl_i,
    input wire logic uv_main_i,
    input wire logic uv_card_i,
    input wire logic [1:0] gpio_i,
    output logic bp_sda_o,
    output logic bp_sda_oe_o,
    output logic connect_o,
    output logic accel_bp_o,
    output logic accel_card_o,
    output logic [1:0] gpio_o,
    output logic [1:0] gpio_oe_o
);

    typedef struct packed {
        bbcc_state_t st;
        logic [2:0] bcnt;
        logic full;
        logic [1:0] nbyte;
        logic [7:0] sh;
        logic rw;
        logic [7:0] pend1;
        logic [7:0] pend2;
        logic pv1;
        logic pv2;
        logic [2:0] r1;
        logic [5:0] r2;
        logic sda_p;
        logic scl_p;
        logic oe;
        logic drv;
        logic [1:0] uv_s1;
        logic [1:0] uv_s2;
        logic [1:0] gp_s1;
        logic [1:0] gp_s2;
        bbcc_ctl_t ctl;
    } bbcc_core_st_t;

    bbcc_core_st_t q;
    bbcc_core_st_t d;
    bbcc_lines_t raw;
    bbcc_lines_t filt;
    logic core_rstn;
    logic sda;
    logic scl;
    logic start_evt;
    logic stop_evt;
    logic scl_rise;
    logic scl_fall;
    logic [7:0] rdb;

    // ==========================================================
    // Reset: card attach low clears registers asynchronously
    assign core_rstn = rstn_i & card_attach_i; // R1

    // Line filtering
    assign raw = '{bp_sda: bp_sda_i, bp_scl: bp_scl_i, cd_sda: card_sda_i, cd_scl: card_scl_i};

    bbcc_glitch_filter u_filt (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .raw_i(raw),
        .filt_o(filt)
    );

    // ==========================================================
    // Helpers
    function automatic logic [1:0] sat_inc(input logic [1:0] v);
        sat_inc = (v == 2'h3) ? v : v + 2'h1;
    endfunction

    function automatic logic [7:0] rd_byte(input logic [1:0] idx, input logic [2:0] r1,
                                           input logic [5:0] r2, input logic [1:0] gp);
        rd_byte = (idx == 2'h0) ? {r1, gp, R1_PAD} : {r2, R2_PAD}; // R10
    endfunction

    // Card lines heard only while connected
    assign sda = filt.bp_sda & (q.ctl.connect ? filt.cd_sda : 1'b1); // R9
    assign scl = filt.bp_scl & (q.ctl.connect ? filt.cd_scl : 1'b1); // R9

    // Bus conditions
    assign start_evt = scl && q.scl_p && q.sda_p && !sda;
    assign stop_evt = scl && q.scl_p && !q.sda_p && sda;
    assign scl_rise = scl && !q.scl_p;
    assign scl_fall = !scl && q.scl_p;
    assign rdb = rd_byte(q.nbyte, q.r1, q.r2, q.gp_s2);

    // ==========================================================
    // Slave sequencing and register update
    always_comb begin
        d = q;
        d.sda_p = sda;
        d.scl_p = scl;
        d.uv_s1 = {uv_card_i, uv_main_i};
        d.uv_s2 = q.uv_s1;
        d.gp_s1 = gpio_i;
        d.gp_s2 = q.gp_s1;
        d.drv = 1'b0;
        if (start_evt) begin
            d.st = ST_ADDR;
            d.bcnt = 3'h0;
            d.full = 1'b0;
            d.nbyte = 2'h0;
            d.oe = 1'b0;
            d.pv1 = 1'b0; // R8
            d.pv2 = 1'b0; // R8
        end else if (stop_evt) begin
            d.st = ST_IDLE;
            d.oe = 1'b0;
            d.pv1 = 1'b0;
            d.pv2 = 1'b0;
            if (q.pv1) begin
                d.r1 = q.pend1[7:5]; // R8 R3
            end
            if (q.pv2) begin
                d.r2 = q.pend2[7:2]; // R8
            end
        end else if (scl_rise) begin
            unique case (q.st)
                ST_ADDR, ST_WR: begin
                    d.sh = {q.sh[6:0], sda};
                    d.bcnt = q.bcnt + 3'h1;
                    d.full = (q.bcnt == 3'h7);
                end
                ST_RD: begin
                    d.bcnt = q.bcnt + 3'h1;
                    d.full = (q.bcnt == 3'h7);
                end
                ST_RACK: begin
                    if (sda) begin
                        d.st = ST_IDLE;
                    end else begin
                        d.st = ST_RD;
                        d.sh = rdb;
                        d.nbyte = sat_inc(q.nbyte);
                        d.bcnt = 3'h0;
                        d.full = 1'b0;
                    end
                end
                ST_IDLE, ST_AACK, ST_WACK: begin
                end
                default: d.st = ST_IDLE;
            endcase
        end else if (scl_fall) begin
            unique case (q.st)
                ST_ADDR: begin
                    if (q.full) begin
                        d.full = 1'b0;
                        if (q.sh[7:1] == DEV_ADDR) begin
                            d.oe = 1'b1;
                            d.st = ST_AACK;
                            d.rw = q.sh[0];
                        end else begin
                            d.st = ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    d.bcnt = 3'h0;
                    if (q.rw) begin
                        d.st = ST_RD;
                        d.sh = rdb;
                        d.nbyte = sat_inc(q.nbyte);
                        d.oe = ~rdb[7];
                    end else begin
                        d.st = ST_WR;
                        d.oe = 1'b0;
                    end
                end
                ST_WR: begin
                    if (q.full) begin
                        d.full = 1'b0;
                        d.oe = 1'b1;
                        d.st = ST_WACK;
                        d.nbyte = sat_inc(q.nbyte);
                        if (q.nbyte == 2'h0) begin
                            d.pend1 = q.sh; // R11
                            d.pv1 = 1'b1;
                        end else if (q.nbyte == 2'h1) begin
                            d.pend2 = q.sh; // R11
                            d.pv2 = 1'b1;
                        end
                    end
                end
                ST_WACK: begin
                    d.oe = 1'b0;
                    d.st = ST_WR;
                end
                ST_RD: begin
                    if (q.full) begin
                        d.full = 1'b0;
                        d.oe = 1'b0;
                        d.st = ST_RACK;
                    end else begin
                        d.oe = ~q.sh[3'h7 - q.bcnt];
                    end
                end
                ST_IDLE, ST_RACK: begin
                end
                default: d.st = ST_IDLE;
            endcase
        end
        // Registered controls; undervoltage forces the switch open
        d.ctl.connect = q.r1[R1_CARD_ATTACH_INPUT_BIT] & ~|q.uv_s2; // R6 R7
        d.ctl.acc_bp = q.r1[R1_ACC_BP_BIT]; // R4
        d.ctl.acc_cd = q.r1[R1_ACC_CD_BIT]; // R4
        for (int i = 0; i < 2; i++) begin
            d.ctl.gpio_oe[i] = !q.r2[R2_IN_LSB + i] &&
                               (q.r2[R2_PP_LSB + i] || !q.r2[R2_LVL_LSB + i]); // R2
            d.ctl.gpio_out[i] = q.r2[R2_PP_LSB + i] & q.r2[R2_LVL_LSB + i];
        end
    end

    // State register, default values under reset
    always_ff @(posedge clk_i or negedge core_rstn) begin
        if (!core_rstn) begin
            q <= '0;
            q.r1 <= R1_RST; // R1 R2
            q.r2 <= R2_RST; // R2
            q.sda_p <= 1'b1;
            q.scl_p <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from state
    assign bp_sda_o = q.drv;
    assign bp_sda_oe_o = q.oe;
    assign connect_o = q.ctl.connect;
    assign accel_bp_o = q.ctl.acc_bp;
    assign accel_card_o = q.ctl.acc_cd;
    assign gpio_o = q.ctl.gpio_out;
    assign gpio_oe_o = q.ctl.gpio_oe;

    // ==========================================================
    // Checks
    property p_uv_break;
        @(posedge clk_i) disable iff (!core_rstn)
        (|q.uv_s2) |=> !connect_o;
    endproperty
    a_uv_break: assert property (p_uv_break) else $error("connected during undervoltage"); // R6

    property p_iso;
        @(posedge clk_i) disable iff (!core_rstn)
        !q.r1[R1_CARD_ATTACH_INPUT_BIT] |=> !connect_o;
    endproperty
    a_iso: assert property (p_iso) else $error("connected without command"); // R7

    property p_commit;
        @(posedge clk_i) disable iff (!core_rstn)
        (q.r1 != $past(q.r1)) |-> $past(stop_evt && q.pv1);
    endproperty
    a_commit: assert property (p_commit) else $error("register changed without stop"); // R8

    property p_drop;
        @(posedge clk_i) disable iff (!core_rstn)
        start_evt ##1 (!stop_evt [*2]) |-> (q.r1 == $past(q.r1, 2)) && !q.pv1;
    endproperty
    a_drop: assert property (p_drop) else $error("pending bytes kept over start"); // R8

    property p_rd1;
        @(posedge clk_i) disable iff (!core_rstn)
        (q.st == ST_RD && q.nbyte == 2'h1) |-> q.sh[2:0] == R1_PAD;
    endproperty
    a_rd1: assert property (p_rd1) else $error("first register low bits not zero"); // R10

    property p_third;
        @(posedge clk_i) disable iff (!core_rstn)
        (scl_fall && q.st == ST_WR && q.full && q.nbyte == WR_DISCARD_IDX && !stop_evt
         && !start_evt) |=> $stable(q.pend1) && $stable(q.pend2) && q.oe;
    endproperty
    a_third: assert property (p_third) else $error("third byte not dropped or not acked"); // R11

    property p_side;
        @(posedge clk_i) disable iff (!core_rstn)
        !q.ctl.connect |-> (sda == filt.bp_sda) && (scl == filt.bp_scl);
    endproperty
    a_side: assert property (p_side) else $error("card lines heard while isolated"); // R9

    property p_accel;
        @(posedge clk_i) disable iff (!core_rstn)
        ##1 {accel_bp_o, accel_card_o} ==
            $past({q.r1[R1_ACC_BP_BIT], q.r1[R1_ACC_CD_BIT]});
    endproperty
    a_accel: assert property (p_accel) else $error("accelerator enable mismatch"); // R4

endmodule

// *** bbcc_glitch_filter.sv ***
// Two-stage synchroniser and persistence filter for the four bus lines.
// Assumes idle-high open-drain lines sampled by the 100 MHz clock.
`timescale 1ns/1ps
module bbcc_glitch_filter
    import bbcc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire bbcc_lines_t raw_i,
    output bbcc_lines_t filt_o
);

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] out;
        logic [3:0][FILT_CW-1:0] cnt;
    } bbcc_filt_st_t;

    bbcc_filt_st_t q;
    bbcc_filt_st_t d;
    logic [3:0] full;

    // ==========================================================
    // Filter next state
    always_comb begin
        d = q;
        d.s1 = raw_i;
        d.s2 = q.s1;
        for (int i = 0; i < 4; i++) begin
            full[i] = (q.cnt[i] == FILT_CW'(FILT_CYC - 1));
            if (q.s2[i] == q.out[i]) begin
                d.cnt[i] = '0;
            end else if (full[i]) begin
                d.out[i] = q.s2[i]; // R5 R12
                d.cnt[i] = '0;
            end else begin
                d.cnt[i] = q.cnt[i] + 3'h1;
            end
        end
    end

    // Register state; lines idle high
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '{s1: 4'hf, s2: 4'hf, out: 4'hf, cnt: '0};
        end else begin
            q <= d;
        end
    end

    assign filt_o = q.out;

    // ==========================================================
    // Checks
    property p_filt_hold;
        @(posedge clk_i) disable iff (!rstn_i)
        ((q.out ^ $past(q.out)) & ~$past(full)) == 4'h0;
    endproperty
    a_filt_hold: assert property (p_filt_hold) else $error("filter passed short pulse"); // R5

    property p_filt_pass;
        @(posedge clk_i) disable iff (!rstn_i)
        (full[0] && q.s2[0] != q.out[0]) |=> (q.out[0] == $past(q.s2[0]));
    endproperty
    a_filt_pass: assert property (p_filt_pass) else $error("filter lost stable level"); // R12

endmodule

// *** bbcc_i2c_master.sv ***
// Two-wire bus master that works one bus from tasks of the bench.
// Assumes pull-ups outside: a high output means the line is released.
`timescale 1ns/1ps
module bbcc_i2c_master
    import bbcc_pkg::*;
(
    input wire logic clk_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic scl_o
);
    // ==========================================================
    // Line phases
    // Phase length in clocks, well above the filter window
    localparam int Q = 13;

    // Released bus at time zero
    initial begin
        sda_o = 1'b1;
        scl_o = 1'b1;
    end

    // Drive both lines, then hold for one phase
    task automatic set(input logic c, input logic d);
        scl_o <= c;
        sda_o <= d;
        repeat (Q) @(posedge clk_i);
    endtask

    // Data falls while clock high; also serves as repeated start
    task automatic start();
        set(scl_o, 1'b1);
        set(1'b1, 1'b1);
        set(1'b1, 1'b0);
        set(1'b0, 1'b0);
    endtask

    // Data rises while clock high
    task automatic stop();
        set(1'b0, 1'b0);
        set(1'b1, 1'b0);
        set(1'b1, 1'b1);
    endtask

    // One byte MSB first, then the ninth bit; samples at end of high
    task automatic xbyte(input logic [7:0] w, input logic mack,
                         output logic [7:0] r, output logic a);
        logic [8:0] s;
        for (int i = 8; i >= 0; i--) begin
            set(1'b0, (i > 0) ? w[i-1] : mack);
            set(1'b1, sda_o);
            s[i] = sda_i;
        end
        set(1'b0, sda_o);
        r = s[8:1];
        a = s[0];
    endtask

    // Data held low under high clock, with a 50 ns high spike in it
    task automatic glitch();
        set(1'b0, 1'b0);
        set(1'b1, 1'b0);
        sda_o <= 1'b1;
        repeat (5) @(posedge clk_i);
        sda_o <= 1'b0;
        repeat (Q) @(posedge clk_i);
        set(1'b0, 1'b0);
    endtask
endmodule

// *** bbcc_pkg.sv ***
// Shared constants and types for the bus buffer connect control block.
// Assumes a single 100 MHz clock; all pins except the resets rstn_i and card_attach_i are sampled into that domain.
package bbcc_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int FILT_MIN_NS = 50;
    // Samples a level must persist; two extra cover sampling phase
    localparam int FILT_CYC = (FILT_MIN_NS / CLK_PERIOD_NS) + 2;
    localparam int FILT_CW = 3;

    // ==========================================================
    // Slave address (value arbitrary)
    localparam logic [6:0] DEV_ADDR_DEF = 7'h2a;

    // ==========================================================
    // First register: three control bits in [7:5]
    localparam int R1_CARD_ATTACH_INPUT_BIT = 2;
    localparam int R1_ACC_BP_BIT = 1;
    localparam int R1_ACC_CD_BIT = 0;
    localparam logic [2:0] R1_RST = 3'h0;
    localparam logic [2:0] R1_PAD = 3'h0;
    // Second register: six control bits in [7:2]
    localparam int R2_PP_LSB = 4;
    localparam int R2_IN_LSB = 2;
    localparam int R2_LVL_LSB = 0;
    localparam logic [5:0] R2_RST = 6'h03;
    localparam logic [1:0] R2_PAD = 2'h3;
    // Write byte index that is acknowledged but dropped
    localparam logic [1:0] WR_DISCARD_IDX = 2'h2;

    // ==========================================================
    // Types
    typedef struct packed {
        logic bp_sda;
        logic bp_scl;
        logic cd_sda;
        logic cd_scl;
    } bbcc_lines_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_AACK = 3'h2,
        ST_WR = 3'h3,
        ST_WACK = 3'h4,
        ST_RD = 3'h5,
        ST_RACK = 3'h6
    } bbcc_state_t;

    typedef struct packed {
        logic connect;
        logic acc_bp;
        logic acc_cd;
        logic [1:0] gpio_out;
        logic [1:0] gpio_oe;
    } bbcc_ctl_t;

endpackage

// *** tb_bus_buffer_connect_control.sv ***
// Self-checking bench of the connect control block with one bus master.
// Assumes the master can be routed to the backplane or the card lines.
`timescale 1ns/1ps
module tb_bus_buffer_connect_control;
    import bbcc_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic card_attach_i = 1'b1;
    logic uv_main_i = 1'b0;
    logic uv_card_i = 1'b0;
    logic [1:0] gpio_i = 2'h0;
    logic sel_card = 1'b0;
    logic m_sda, m_scl, bp_sda_i, bp_scl_i, card_sda_i, card_scl_i, m_in;
    logic bp_sda_o, bp_sda_oe_o, connect_o, accel_bp_o, accel_card_o;
    logic [1:0] gpio_o, gpio_oe_o;
    logic [7:0] cur1 = 8'h00;
    logic [7:0] cur2 = 8'h0f;
    logic [7:0] b1, b2, r;
    logic a;
    int n_mismatch = 0;
    int samples_checked = 0;

    // ==========================================================
    // Clock, wires and instances
    always #5 clk_i = ~clk_i;
    // Unused side idles high; slave pull-down joins the backplane data
    assign bp_scl_i = sel_card | m_scl;
    assign bp_sda_i = (sel_card | m_sda) & (bp_sda_oe_o ? bp_sda_o : 1'b1);
    assign card_scl_i = ~sel_card | m_scl;
    assign card_sda_i = ~sel_card | m_sda;
    assign m_in = sel_card ? card_sda_i & ~(connect_o & bp_sda_oe_o) : bp_sda_i;

    bbcc_i2c_master bbcc_i2c_master_inst (.clk_i(clk_i), .sda_i(m_in),
        .sda_o(m_sda), .scl_o(m_scl));
    bbcc_connect_ctl bbcc_connect_ctl_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .card_attach_i(card_attach_i), .bp_sda_i(bp_sda_i), .bp_scl_i(bp_scl_i),
        .card_sda_i(card_sda_i), .card_scl_i(card_scl_i), .uv_main_i(uv_main_i),
        .uv_card_i(uv_card_i), .gpio_i(gpio_i), .bp_sda_o(bp_sda_o),
        .bp_sda_oe_o(bp_sda_oe_o), .connect_o(connect_o), .accel_bp_o(accel_bp_o),
        .accel_card_o(accel_card_o), .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o));

    // ==========================================================
    // Expectations and checks
    function automatic logic [1:0] goe(input logic [7:0] b);
        for (int i = 0; i < 2; i++) goe[i] = !b[4+i] && (b[6+i] || !b[2+i]);
    endfunction
    function automatic logic [1:0] gpo(input logic [7:0] b);
        for (int i = 0; i < 2; i++) gpo[i] = b[6+i] && b[2+i];
    endfunction

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
            n_mismatch++;
        end
    endtask

    // Control outputs against the expected registers
    task automatic chk_out();
        chk({1'b0, connect_o, accel_bp_o, accel_card_o, gpio_o, gpio_oe_o},
            {1'b0, cur1[7] & ~(uv_main_i | uv_card_i), cur1[6:5],
             gpo(cur2), goe(cur2)});
    endtask

    // Write n bytes of w; stop commits them unless held back
    task automatic wr(input logic [23:0] w, input int n, input logic eack);
        bbcc_i2c_master_inst.start();
        bbcc_i2c_master_inst.xbyte({DEV_ADDR_DEF, 1'b0}, 1'b1, r, a);
        chk({7'h0, a}, {7'h0, eack});
        for (int k = 0; k < n; k++) begin
            bbcc_i2c_master_inst.xbyte(w[23-8*k -: 8], 1'b1, r, a);
            chk({7'h0, a}, {7'h0, eack});
        end
        bbcc_i2c_master_inst.stop();
        repeat (10) @(posedge clk_i);
    endtask

    // Read both registers, then the outputs
    task automatic chk_all();
        bbcc_i2c_master_inst.start();
        bbcc_i2c_master_inst.xbyte({DEV_ADDR_DEF, 1'b1}, 1'b1, r, a);
        chk({7'h0, a}, 8'h00);
        bbcc_i2c_master_inst.xbyte(8'hff, 1'b0, r, a);
        chk(r, {cur1[7:5], gpio_i, 3'h0});
        bbcc_i2c_master_inst.xbyte(8'hff, 1'b1, r, a);
        chk(r, cur2);
        bbcc_i2c_master_inst.stop();
        chk_out();
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Watchdog on the whole run
    initial begin
        repeat (100000) @(posedge clk_i);
        n_mismatch++;
        end_of_test();
    end

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'hecdf9d6d));
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk_all();
        // Accelerator combinations, connect, random GPIO modes
        for (int i = 0; i < 8; i++) begin
            b1 = 8'($urandom);
            b2 = 8'($urandom);
            b1[7:5] = i[2:0];
            gpio_i <= 2'($urandom);
            wr({b1, b2, 8'($urandom)}, 2 + i % 2, 1'b0);
            cur1 = b1;
            cur2 = {b2[7:2], 2'h3};
            chk_all();
        end
        // Foreign address: no ack, bytes ignored
        bbcc_i2c_master_inst.start();
        bbcc_i2c_master_inst.xbyte({DEV_ADDR_DEF ^ 7'($urandom_range(127, 1)), 1'b0}, 1'b1, r, a);
        chk({7'h0, a}, 8'h01);
        bbcc_i2c_master_inst.xbyte(~cur1, 1'b1, r, a);
        chk({7'h0, a}, 8'h01);
        bbcc_i2c_master_inst.stop();
        // Pending bytes, filtered spike, repeated start then stop
        bbcc_i2c_master_inst.start();
        bbcc_i2c_master_inst.xbyte({DEV_ADDR_DEF, 1'b0}, 1'b1, r, a);
        bbcc_i2c_master_inst.xbyte(~cur1, 1'b1, r, a);
        bbcc_i2c_master_inst.glitch();
        bbcc_i2c_master_inst.start();
        bbcc_i2c_master_inst.stop();
        chk_all();
        // Undervoltage on either supply
        for (int u = 0; u < 3; u++) begin
            uv_main_i <= (u == 0);
            uv_card_i <= (u == 1);
            repeat (10) @(posedge clk_i);
            chk_out();
        end
        // Card side refused while apart, heard once joined
        wr({8'h00, cur2, 8'h00}, 2, 1'b0);
        cur1 = 8'h00;
        sel_card <= 1'b1;
        repeat (10) @(posedge clk_i);
        wr({8'he0, cur2, 8'h00}, 2, 1'b1);
        chk_out();
        sel_card <= 1'b0;
        wr({8'h80, cur2, 8'h00}, 2, 1'b0);
        sel_card <= 1'b1;
        wr({8'ha0, cur2, 8'h00}, 2, 1'b0);
        cur1 = 8'ha0;
        chk_out();
        sel_card <= 1'b0;
        // Card attach low clears registers at once
        @(posedge clk_i);
        card_attach_i <= 1'b0;
        #1;
        cur1 = 8'h00;
        cur2 = 8'h0f;
        chk_out();
        @(posedge clk_i);
        card_attach_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk_all();
        end_of_test();
    end
endmodule
